// [hdl/trip_pkg.sv]
// Purpose: Constants and types shared by the trip fault logger
// Assumes: 125 MHz system clock
// Notes:   Fault codes are the decimal code numbers held in 8 bits
package trip_pkg;
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned STOP_WAIT_S     = 100;
    localparam longint unsigned STOP_WAIT_CYC =
        longint'(STOP_WAIT_S) * longint'(CLK_HZ);
    localparam int          CODE_W          = 8;
    localparam int          DATA_W          = 16;
    localparam logic [1:0]  HIST_CLEAR_VAL  = 2'h0;
    localparam logic [7:0]  CODE_NONE       = 8'h00;
    localparam logic [7:0]  CODE_OC_CONST   = 8'h01;
    localparam logic [7:0]  CODE_OC_DECEL   = 8'h02;
    localparam logic [7:0]  CODE_OC_ACCEL   = 8'h03;
    localparam logic [7:0]  CODE_OC_OTHER   = 8'h04;
    localparam logic [7:0]  CODE_OVERLOAD   = 8'h05;
    localparam logic [7:0]  CODE_BRAKE_RES  = 8'h06;
    localparam logic [7:0]  CODE_OVER_VOLT  = 8'h07;
    localparam logic [7:0]  CODE_NVM        = 8'h08;
    localparam logic [7:0]  CODE_UNDER_VOLT = 8'h09;
    localparam logic [7:0]  CODE_CPU        = 8'h0b;
    localparam logic [7:0]  CODE_EXT_TRIP   = 8'h0c;
    localparam logic [7:0]  CODE_START_GRD  = 8'h0d;
    localparam logic [7:0]  CODE_GND_FAULT  = 8'h0e;
    localparam logic [7:0]  CODE_IN_OVERV   = 8'h0f;
    localparam logic [7:0]  CODE_THERMAL    = 8'h15;
    localparam logic [7:0]  CODE_CPU_ALT    = 8'h16;
    localparam logic [7:0]  CODE_GATE_ARR   = 8'h17;
    localparam logic [7:0]  CODE_THERMISTOR = 8'h23;
    localparam logic [7:0]  CODE_COMMS      = 8'h3c;
    localparam int unsigned RESTART_TRY_CYC = 1000;
    typedef enum logic [1:0] {
        PH_CONST,
        PH_DECEL,
        PH_ACCEL,
        PH_OTHER
    } motion_phase_t;
    typedef enum logic [1:0] {
        BO_IDLE,
        BO_RESTART
    } brownout_t;
endpackage

// [hdl/trip_hist_if.sv]
// Purpose: Carries a history push or erase between logger modules
// Assumes: Single clock
// Notes:   push and erase are one-cycle pulses
`timescale 1ns/1ps
interface trip_hist_if;
    import trip_pkg::*;
    logic              push;
    logic              erase;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] newest;
    logic [CODE_W-1:0] previous;
    logic [CODE_W-1:0] oldest;
    modport ctrl (output push, output erase, output code,
                  input newest, input previous, input oldest);
    modport hist (input push, input erase, input code,
                  output newest, output previous, output oldest);
endinterface

// [hdl/trip_history.sv]
// Purpose: Three-deep trip history, newest to oldest
// Assumes: Driven by the trip fault logger
// Notes:   Erase beats a push in the same cycle
`timescale 1ns/1ps
module trip_history
    import trip_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // History port
    trip_hist_if.hist hif
);
    logic [CODE_W-1:0] slot_r [3];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            slot_r <= '{CODE_NONE, CODE_NONE, CODE_NONE};
        end else if (hif.erase) begin
            slot_r <= '{CODE_NONE, CODE_NONE, CODE_NONE};
        end else if (hif.push) begin
            slot_r <= '{hif.code, slot_r[0], slot_r[1]};
        end
    end

    assign hif.newest   = slot_r[0];
    assign hif.previous = slot_r[1];
    assign hif.oldest   = slot_r[2];
endmodule

// [hdl/trip_fault_logger.sv]
// Purpose: Fault trip, code latch, snapshot and history control
// Assumes: Fault inputs are asynchronous levels from the drive
// Notes:   One trip is held until the stop/reset key is pressed
`timescale 1ns/1ps
// Overview of operation
// - Any fault turns the output off and records the trip in history.
// - Faults are accepted while stopped as well as while running.
// - A stop/reset key press clears the present trip.
// - History-clear select at value 00 erases history, nothing else.
// - The latched error code is shown on the display at once.
// - Over-current code depends on constant, decel, accel or other phase.
// - Overload, braking resistor and bus over-voltage have own codes.
// - Memory problem and bus under-voltage trip with their codes.
// - CPU malfunction and external trip input trip with their codes.
// - Run present at power-up with guard enabled trips; run refused.
// - Ground fault seen in power-up test trips with its code.
// - Input over-voltage tested only after 100 s stopped.
// - Module heat, gate array link and thermistor have own codes.
// - Network watchdog expiry trips with the communications code.
// - Brown-out shuts output and retries; failed retry trips under-volt.
// - Power lost with reset input active gives memory error next power.
// - Operating data is captured at each new trip and held until the next.
// - New error shifts newest to previous, previous to oldest.
module trip_fault_logger
    import trip_pkg::*;
#(
    parameter longint unsigned STOP_WAIT   = STOP_WAIT_CYC,
    parameter int unsigned     RESTART_TRY = RESTART_TRY_CYC
)(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // Drive state
    input  wire logic              run_cmd,
    input  wire logic [1:0]        motion_phase,
    input  wire logic              restart_ok,
    input  wire logic [DATA_W-1:0] freq_now,
    input  wire logic [DATA_W-1:0] current_now,
    input  wire logic [DATA_W-1:0] bus_volt_now,
    // Fault reports
    input  wire logic              over_current,
    input  wire logic              motor_overload,
    input  wire logic              brake_overrun,
    input  wire logic              bus_over_volt,
    input  wire logic              nvm_fault,
    input  wire logic              bus_under_volt,
    input  wire logic              cpu_fault,
    input  wire logic              external_trip_input,
    input  wire logic              ground_fault,
    input  wire logic              input_over_volt,
    input  wire logic              module_over_temp,
    input  wire logic              gate_array_fault,
    input  wire logic              thermistor_hot,
    input  wire logic              comms_watchdog,
    input  wire logic              brownout,
    // Power-up and keypad
    input  wire logic              unattended_start_guard,
    input  wire logic              reset_input_terminal,
    input  wire logic              nvm_reset_mark,
    input  wire logic              powerup_test,
    input  wire logic              stop_reset_key,
    input  wire logic [1:0]        history_clear_select,
    input  wire logic              history_clear_strobe,
    // Outputs to power stage and display
    output logic                   output_enable,
    output logic                   tripped,
    output logic                   run_allowed,
    output logic [CODE_W-1:0]      display_code,
    output logic [CODE_W-1:0]      newest_fault_monitor,
    output logic [CODE_W-1:0]      previous_fault_monitor,
    output logic [CODE_W-1:0]      oldest_fault_monitor,
    output logic [DATA_W-1:0]      snap_freq,
    output logic [DATA_W-1:0]      snap_current,
    output logic [DATA_W-1:0]      snap_bus_volt,
    output logic                   reset_mark_set
);
    localparam int NIN = 23;

    // Two-stage synchronisers on every outside level
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    assign raw_in = {over_current, motor_overload, brake_overrun,
                     bus_over_volt, nvm_fault, bus_under_volt, cpu_fault,
                     external_trip_input, ground_fault, input_over_volt,
                     module_over_temp, gate_array_fault, thermistor_hot,
                     comms_watchdog, brownout, unattended_start_guard,
                     reset_input_terminal, nvm_reset_mark, powerup_test,
                     stop_reset_key, history_clear_strobe, run_cmd,
                     restart_ok};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    wire s_oc      = sync2_r[22];
    wire s_ovl     = sync2_r[21];
    wire s_brk     = sync2_r[20];
    wire s_ovv     = sync2_r[19];
    wire s_nvm     = sync2_r[18];
    wire s_uv      = sync2_r[17];
    wire s_cpu     = sync2_r[16];
    wire s_ext     = sync2_r[15];
    wire s_gnd     = sync2_r[14];
    wire s_inov    = sync2_r[13];
    wire s_temp    = sync2_r[12];
    wire s_gate    = sync2_r[11];
    wire s_therm   = sync2_r[10];
    wire s_comm    = sync2_r[9];
    wire s_bo      = sync2_r[8];
    wire s_guard   = sync2_r[7];
    wire s_rst_in  = sync2_r[6];
    wire s_nvmark  = sync2_r[5];
    wire s_putest  = sync2_r[4];
    wire s_key     = sync2_r[3];
    wire s_clr     = sync2_r[2];
    wire s_run     = sync2_r[1];
    wire s_rst_ok  = sync2_r[0];

    // Phase and clear select get their own two-flop stages
    // Bits may skew for one cycle; phase moves far slower than that
    logic [1:0] phase_s1_r;
    logic [1:0] phase_s2_r;
    logic [1:0] sel_s1_r;
    logic [1:0] sel_s2_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_s1_r <= 2'h0;
            phase_s2_r <= 2'h0;
            sel_s1_r   <= 2'h0;
            sel_s2_r   <= 2'h0;
        end else begin
            phase_s1_r <= motion_phase;
            phase_s2_r <= phase_s1_r;
            sel_s1_r   <= history_clear_select;
            sel_s2_r   <= sel_s1_r;
        end
    end

    // Edge detect on keypad and history strobe
    logic key_d_r;
    logic clr_d_r;
    logic first_r;
    wire  key_press  = s_key & ~key_d_r;
    wire  clr_pulse  = s_clr & ~clr_d_r;

    // Power-up checks run once, after synchronisers have settled
    logic [1:0] settle_r;
    wire  pu_check = first_r && (settle_r == 2'h2);

    // Stopped-time counter for the input over-voltage test
    logic [$clog2(STOP_WAIT+1)-1:0] stop_cnt_r;
    wire  stopped     = ~s_run | tripped;
    wire  stop_done   = (stop_cnt_r == STOP_WAIT[$bits(stop_cnt_r)-1:0]);

    // Brown-out restart sequencing
    brownout_t bo_r;
    logic [$clog2(RESTART_TRY+1)-1:0] bo_cnt_r;
    wire  bo_fail = (bo_r == BO_RESTART) &&
                    (bo_cnt_r == RESTART_TRY[$bits(bo_cnt_r)-1:0]) &&
                    ~s_rst_ok;

    // Over-current code by motion phase
    logic [CODE_W-1:0] oc_code;
    always_comb begin
        case (motion_phase_t'(phase_s2_r))
            PH_CONST: oc_code = CODE_OC_CONST;
            PH_DECEL: oc_code = CODE_OC_DECEL;
            PH_ACCEL: oc_code = CODE_OC_ACCEL;
            default:  oc_code = CODE_OC_OTHER;
        endcase
    end

    // Fixed priority: hardware integrity, over-current, bus voltage, heat, load, then the rest
    logic [CODE_W-1:0] fault_code;
    wire  pu_nvm   = pu_check & s_nvmark;
    wire  pu_guard = pu_check & s_guard & s_run;
    wire  pu_gnd   = pu_check & s_putest & s_gnd;
    // Gated by stopped: a run arriving with the fault is not tested
    wire  inov_hit = stop_done & stopped & s_inov;
    assign fault_code =
        (s_cpu)    ? CODE_CPU        :
        (s_gate)   ? CODE_GATE_ARR   :
        (s_nvm | pu_nvm) ? CODE_NVM  :
        (pu_gnd)   ? CODE_GND_FAULT  :
        (s_oc)     ? oc_code         :
        (s_ovv)    ? CODE_OVER_VOLT  :
        (s_uv | bo_fail) ? CODE_UNDER_VOLT :
        (s_temp)   ? CODE_THERMAL    :
        (s_therm)  ? CODE_THERMISTOR :
        (s_ovl)    ? CODE_OVERLOAD   :
        (s_brk)    ? CODE_BRAKE_RES  :
        (inov_hit) ? CODE_IN_OVERV   :
        (s_ext)    ? CODE_EXT_TRIP   :
        (s_comm)   ? CODE_COMMS      :
        (pu_guard) ? CODE_START_GRD  :
                     CODE_NONE;

    // Accepted in any run state; only the first fault while tripped counts
    wire new_trip = (fault_code != CODE_NONE) && !tripped;

    // History control
    trip_hist_if hif ();
    assign hif.push  = new_trip;
    assign hif.code  = fault_code;
    assign hif.erase = clr_pulse &&
                       (sel_s2_r == HIST_CLEAR_VAL);

    trip_history u_history (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .hif     (hif)
    );

    assign newest_fault_monitor   = hif.newest;
    assign previous_fault_monitor = hif.previous;
    assign oldest_fault_monitor   = hif.oldest;

    // Output is held off while tripped or during a brown-out retry
    assign output_enable = ~tripped & (bo_r == BO_IDLE) & s_run;
    assign run_allowed   = ~tripped;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_d_r  <= 1'b0;
            clr_d_r  <= 1'b0;
            first_r  <= 1'b1;
            settle_r <= 2'h0;
        end else begin
            key_d_r  <= s_key;
            clr_d_r  <= s_clr;
            if (settle_r != 2'h2)
                settle_r <= settle_r + 2'h1;
            else
                first_r <= 1'b0;
        end
    end

    // Trip latch; a new fault beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tripped      <= 1'b0;
            display_code <= CODE_NONE;
        end else if (new_trip) begin
            tripped      <= 1'b1;
            display_code <= fault_code;
        end else if (key_press) begin
            tripped      <= 1'b0;
            display_code <= CODE_NONE;
        end
    end

    // Snapshot of operating data at the trip
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            snap_freq     <= '0;
            snap_current  <= '0;
            snap_bus_volt <= '0;
        end else if (new_trip) begin
            snap_freq     <= freq_now;
            snap_current  <= current_now;
            snap_bus_volt <= bus_volt_now;
        end
    end

    // Counts continuous stopped time; restarts on a run while not tripped
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stop_cnt_r <= '0;
        end else if (!stopped) begin
            stop_cnt_r <= '0;
        end else if (!stop_done) begin
            stop_cnt_r <= stop_cnt_r + 1'b1;
        end
    end

    // Brown-out: shut off and retry before recording a trip
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bo_r     <= BO_IDLE;
            bo_cnt_r <= '0;
        end else begin
            case (bo_r)
                BO_IDLE: begin
                    bo_cnt_r <= '0;
                    if (s_bo && !tripped)
                        bo_r <= BO_RESTART;
                end
                BO_RESTART: begin
                    if (s_rst_ok || tripped) begin
                        bo_r <= BO_IDLE;
                    end else if (bo_cnt_r !=
                                 RESTART_TRY[$bits(bo_cnt_r)-1:0]) begin
                        bo_cnt_r <= bo_cnt_r + 1'b1;
                    end
                end
                default: bo_r <= BO_IDLE;
            endcase
        end
    end

    // Marks that reset input was active, for the keeper of the nvm flag
    assign reset_mark_set = s_rst_in;
endmodule

// [test/trip_fault_logger_sva.sv]
// Purpose: Port-level checks of the trip fault logger
// Assumes: Three-edge latency from input rise to registered answer
// Notes:   Bound to every instance of the logger
`timescale 1ns/1ps
module trip_fault_logger_sva
    import trip_pkg::*;
(
    // Clock, reset and inputs
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic              cpu_fault,
    input wire logic              history_clear_strobe,
    input wire logic [1:0]        history_clear_select,
    // Outputs
    input wire logic              output_enable,
    input wire logic              tripped,
    input wire logic              run_allowed,
    input wire logic [CODE_W-1:0] display_code,
    input wire logic [CODE_W-1:0] newest_fault_monitor,
    input wire logic [CODE_W-1:0] previous_fault_monitor,
    input wire logic [CODE_W-1:0] oldest_fault_monitor,
    input wire logic [DATA_W-1:0] snap_freq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_off; tripped |-> !output_enable; endproperty
    a_off: assert property (p_off)
        else $error("output on while tripped");
    property p_run; run_allowed == !tripped; endproperty
    a_run: assert property (p_run)
        else $error("run allowed while tripped");
    property p_idle; !tripped |-> display_code == 8'h00; endproperty
    a_idle: assert property (p_idle)
        else $error("code shown without trip");
    property p_show;
        $rose(tripped) |-> display_code == newest_fault_monitor
            && display_code != 8'h00;
    endproperty
    a_show: assert property (p_show)
        else $error("display differs from newest entry");
    property p_shift;
        $rose(tripped) |->
            previous_fault_monitor == $past(newest_fault_monitor)
            && oldest_fault_monitor == $past(previous_fault_monitor);
    endproperty
    a_shift: assert property (p_shift)
        else $error("history did not shift");
    property p_hold;
        tripped && $past(tripped) |-> $stable(display_code);
    endproperty
    a_hold: assert property (p_hold)
        else $error("code changed while tripped");
    property p_snap;
        tripped && $past(tripped) |-> $stable(snap_freq);
    endproperty
    a_snap: assert property (p_snap)
        else $error("snapshot changed while tripped");
    property p_lat; $rose(cpu_fault) && !tripped |-> ##3 tripped; endproperty
    a_lat: assert property (p_lat)
        else $error("fault did not trip in three cycles");
    property p_erase;
        $rose(history_clear_strobe) && history_clear_select == 2'h0 |->
            ##3 {newest_fault_monitor, previous_fault_monitor,
                 oldest_fault_monitor} == 24'h000000;
    endproperty
    a_erase: assert property (p_erase)
        else $error("history not erased");
endmodule
bind trip_fault_logger trip_fault_logger_sva trip_fault_logger_sva_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .cpu_fault(cpu_fault),
    .history_clear_strobe(history_clear_strobe),
    .history_clear_select(history_clear_select),
    .output_enable(output_enable), .tripped(tripped),
    .run_allowed(run_allowed), .display_code(display_code),
    .newest_fault_monitor(newest_fault_monitor),
    .previous_fault_monitor(previous_fault_monitor),
    .oldest_fault_monitor(oldest_fault_monitor), .snap_freq(snap_freq));

// [test/drive_panel_model.sv]
// Purpose: Keypad and power stage facing the trip fault logger
// Assumes: key_req is a one-cycle request from the bench
// Notes:   restart_delay of zero means a restart never succeeds
`timescale 1ns/1ps
module drive_panel_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Bench requests
    input  wire logic       key_req,
    input  wire logic       brownout,
    input  wire logic [7:0] restart_delay,
    // Towards the logger
    output logic            stop_reset_key,
    output logic            restart_ok
);
    logic [2:0] key_cnt_r;
    logic [7:0] bo_cnt_r;
    // Key held 4 cycles so the input sync sees one press
    assign stop_reset_key = key_cnt_r != 3'h0;
    // Restart reported for 4 cycles only, then withdrawn
    assign restart_ok = restart_delay != 8'h00 && bo_cnt_r >= restart_delay
        && bo_cnt_r < restart_delay + 8'h04;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_cnt_r <= 3'h0;
            bo_cnt_r  <= 8'h00;
        end else begin
            key_cnt_r <= key_req ? 3'h4 : key_cnt_r - {2'h0, stop_reset_key};
            bo_cnt_r  <= brownout ? 8'h01 : bo_cnt_r
                + {7'h0, bo_cnt_r != 8'h00 && bo_cnt_r != 8'hff};
        end
    end
endmodule

// [test/trip_fault_logger_bench.sv]
// Purpose: Self-checking bench for the trip fault logger
// Assumes: Short stop wait and restart counts for simulation
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module trip_fault_logger_bench;
    import trip_pkg::*;
    localparam int SW = 20;
    localparam int RT = 10;
    logic        clk_sys = 1'b0, reset_n = 1'b0, run_cmd = 1'b0;
    logic        guard = 1'b0, rst_term = 1'b0, mark = 1'b0, pu_t = 1'b0;
    logic        key_req = 1'b0, strobe = 1'b0;
    logic [1:0]  phase = 2'h0, sel = 2'h1;
    logic [14:0] flt = 15'h0000;
    logic [15:0] freq = 16'h0000;
    logic [7:0]  delay = 8'h00;
    logic        key, rs_ok, oe, trp, run_ok, mk_set;
    logic [7:0]  disp, h0, h1, h2;
    logic [15:0] s_f, s_c, s_v;
    int          err_total = 0, n_tests = 0;
    int          bit_of[11] = '{1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 13};
    logic [7:0]  code_of[11] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0b,
                                 8'h0c, 8'h15, 8'h17, 8'h23, 8'h3c};
    logic [4:0]  pu_in[5] = '{5'h00, 5'h18, 5'h04, 5'h02, 5'h01};
    logic [7:0]  pu_code[5] = '{8'h00, 8'h0d, 8'h0e, 8'h08, 8'h00};
    always #4 clk_sys = ~clk_sys;
    trip_fault_logger #(.STOP_WAIT(SW), .RESTART_TRY(RT))
        trip_fault_logger_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .run_cmd(run_cmd),
        .motion_phase(phase), .restart_ok(rs_ok), .freq_now(freq),
        .current_now(~freq), .bus_volt_now(freq ^ 16'h5a5a),
        .over_current(flt[0]), .motor_overload(flt[1]),
        .brake_overrun(flt[2]), .bus_over_volt(flt[3]), .nvm_fault(flt[4]),
        .bus_under_volt(flt[5]), .cpu_fault(flt[6]),
        .external_trip_input(flt[7]), .ground_fault(flt[8]),
        .input_over_volt(flt[9]), .module_over_temp(flt[10]),
        .gate_array_fault(flt[11]), .thermistor_hot(flt[12]),
        .comms_watchdog(flt[13]), .brownout(flt[14]),
        .unattended_start_guard(guard), .reset_input_terminal(rst_term),
        .nvm_reset_mark(mark), .powerup_test(pu_t), .stop_reset_key(key),
        .history_clear_select(sel), .history_clear_strobe(strobe),
        .output_enable(oe), .tripped(trp), .run_allowed(run_ok),
        .display_code(disp), .newest_fault_monitor(h0),
        .previous_fault_monitor(h1), .oldest_fault_monitor(h2),
        .snap_freq(s_f), .snap_current(s_c), .snap_bus_volt(s_v),
        .reset_mark_set(mk_set));
    drive_panel_model drive_panel_model_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .key_req(key_req),
        .brownout(flt[14]), .restart_delay(delay),
        .stop_reset_key(key), .restart_ok(rs_ok));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic give_verdict;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_trip(input logic want, input int lim);
        for (int i = 0; i < lim && trp !== want; i++) tick(1);
        if (trp !== want) begin
            chk(trp, want);
            give_verdict();
        end
    endtask
    task automatic press;
        key_req = 1'b1;
        tick(1);
        key_req = 1'b0;
        wait_trip(1'b0, 12);
    endtask
    task automatic pu(input logic [4:0] v, input logic [7:0] c);
        {guard, run_cmd, pu_t, mark, rst_term} = v;
        flt[8] = pu_t;
        reset_n = 1'b0;
        tick(10);
        reset_n = 1'b1;
        if (c != 8'h00) wait_trip(1'b1, 8);
        else tick(6);
        chk({disp, h0, h1, h2}, {c, c, 16'h0000});
        chk({run_ok, mk_set}, {c == 8'h00, rst_term});
        {guard, run_cmd, pu_t, mark, rst_term} = 5'h00;
        flt = 15'h0000;
        $display("power-up case %h done", v);
    endtask
    task automatic trip_case(input logic [14:0] m, input logic [7:0] c);
        logic [7:0] p0, p1;
        p0 = h0;
        p1 = h1;
        freq = {c, 8'h3c};
        chk(oe, run_cmd);
        flt = m;
        wait_trip(1'b1, 8);
        chk({disp, h0, h1, h2}, {c, c, p0, p1});
        chk(oe, 1'b0);
        chk({s_f, s_c}, {freq, ~freq});
        chk(s_v, freq ^ 16'h5a5a);
        freq = 16'h0000;
        flt = m | 15'h2000;
        tick(6);
        chk({disp, h0, s_f}, {c, c, c, 8'h3c});
        // Cause removed before the key, else it trips again
        flt = 15'h0000;
        tick(3);
        press();
        chk({disp, run_ok}, {8'h00, 1'b1});
        $display("trip case %h done", c);
    endtask
    task automatic clr(input logic [1:0] s);
        sel = s;
        strobe = 1'b1;
        tick(5);
        strobe = 1'b0;
        tick(1);
    endtask
    initial begin
        foreach (pu_in[k]) pu(pu_in[k], pu_code[k]);
        run_cmd = 1'b1;
        for (int i = 0; i < 4; i++) begin
            phase = i[1:0];
            tick(3);
            trip_case(15'h0001, 8'h01 + i[7:0]);
        end
        run_cmd = 1'b0;
        tick(3);
        foreach (bit_of[k])
            trip_case(15'h0001 << bit_of[k], code_of[k]);
        trip_case(15'h00c0, 8'h0b);
        trip_case(15'h0811, 8'h17);
        run_cmd = 1'b1;
        flt[9] = 1'b1;
        tick(SW + 20);
        chk(trp, 1'b0);
        run_cmd = 1'b0;
        tick(SW + 2);
        chk(trp, 1'b0);
        wait_trip(1'b1, 2);
        chk(disp, 8'h0f);
        flt = 15'h0000;
        press();
        run_cmd = 1'b1;
        delay = 8'h06;
        tick(4);
        chk(oe, 1'b1);
        flt[14] = 1'b1;
        tick(2);
        flt[14] = 1'b0;
        tick(2);
        chk({oe, trp}, 2'b00);
        tick(RT + 10);
        chk({oe, trp}, 2'b10);
        delay = 8'h00;
        flt[14] = 1'b1;
        tick(2);
        flt[14] = 1'b0;
        wait_trip(1'b1, RT + 10);
        chk(disp, 8'h09);
        press();
        clr(2'h1);
        chk(h0, 8'h09);
        clr(2'h0);
        chk({h0, h1, h2, run_ok}, {24'h000000, 1'b1});
        $display("history erase done");
        give_verdict();
    end
endmodule
